// >>> verilog/snf_pkg.sv
`default_nettype none
package snf_pkg;
    // opcodes
    localparam logic [7:0] OP_ERASE = 8'hD8;
    localparam logic [7:0] OP_LATCH_ARM_COMMAND = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_GETF = 8'h0F;
    localparam logic [7:0] OP_SETF = 8'h1F;
    localparam logic [7:0] OP_PGLOAD = 8'h02;
    localparam logic [7:0] OP_PGEXEC = 8'h10;
    localparam logic [7:0] OP_PGREAD = 8'h13;
    localparam logic [7:0] OP_RESET = 8'hFF;
    localparam logic [7:0] OP_QLOAD = 8'h32;
    localparam logic [7:0] OP_QRAND = 8'h34;
    // feature addresses
    localparam logic [7:0] FA_LOCK = 8'hA0;
    localparam logic [7:0] FA_OTP = 8'hB0;
    localparam logic [7:0] FA_STATUS = 8'hC0;
    // lock feature field positions
    localparam int LK_PERM = 7;
    localparam int LK_BP_HI = 5;
    localparam int LK_BP_LO = 3;
    localparam int LK_FLIP = 2;
    localparam int LK_COMP = 1;
    localparam int LK_WRBLK = 0;
    // otp feature field positions
    localparam int OTP_PROT = 7;
    localparam int OTP_EN = 6;
    // status bit positions
    localparam int SR_BUSY = 0;
    localparam int SR_WEL = 1;
    localparam int SR_EFAIL = 2;
    localparam int SR_PFAIL = 3;
    // reset values
    localparam logic [2:0] BP_RESET = 3'h7;
    // geometry: 2Gb part, 17-bit row, 6 page bits inside a block
    localparam int ROW_W = 17;
    localparam int PAGE_W = 6;
    localparam int BLK_W = ROW_W - PAGE_W;
    localparam int ADDR_BITS = 24;
    localparam int OTP_FIRST = 2;
    localparam int OTP_LAST = 31;
    // timing
    localparam int CLK_MHZ = 100;
    localparam int ERASE_US = 1000;
    localparam int ERASE_CYC = ERASE_US * CLK_MHZ;
    localparam int PROG_US = 320;
    localparam int PROG_CYC = PROG_US * CLK_MHZ;
    localparam int READ_US = 25;
    localparam int READ_CYC = READ_US * CLK_MHZ;
    localparam int CNT_W = 24;
    typedef enum logic [2:0] {
        SNF_IDLE, SNF_OPC, SNF_ADDR, SNF_DATA, SNF_OUT, SNF_DROP
    } snf_phase_t;
endpackage : snf_pkg
`default_nettype wire

// >>> verilog/snf_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for one pin; resets to the pin's idle level so no false edge follows reset
module snf_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic d,
    output logic q
);
    logic meta_q;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : snf_sync
`default_nettype wire

// >>> verilog/snf_core.sv
// Functional notes
// - erase D8h sets whole 128K block to ones
// - opcode then 24 address bits, dummy padded
// - any row inside block selects block
// - erase rejected unless deselect on byte boundary
// - erase timer starts at deselect
// - busy during erase, then clear busy, latch
// - status read repeats until next command
// - reset: range bits one, others zero
// - lock bits writable at A0h unless locked
// - decode protected region from lock code
// - block zero is lowest block
// - pin lock mode freezes lock fields; the permanent bit stays writable here
// - no quad loads in pin lock mode
// - permanent lock freezes settings until power cycle
// - 30-page one-time area, pages 02h-1Fh
// - one-time mode at B0h, protect/enable bits
// - one-time program needs protect bit zero
// - protect+enable then execute locks area
// - status bit0 busy, bits7-4 reserved zero
// - latch gates writes, cleared by 04h/completion
// - erase fail flag set/cleared
// - program fail flag set/cleared
// - 06h sets latch; unarmed writes ignored
`timescale 1ns/1ps
`default_nettype none
module snf_core #(
    parameter int ERASE_CYCLES = snf_pkg::ERASE_CYC,
    parameter int PROG_CYCLES = snf_pkg::PROG_CYC,
    parameter int READ_CYCLES = snf_pkg::READ_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic chip_select_n,
    input wire logic serial_clock,
    input wire logic serial_in_line,
    input wire logic write_guard_pin,
    output logic serial_out_line,
    output logic serial_out_oe,
    output logic erase_start,
    output logic [snf_pkg::BLK_W-1:0] erase_block,
    output logic erase_fail_in_unused,
    input wire logic array_fail
);
    import snf_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic cs_s, sck_s, si_s, wp_s;
    // select idles high; a low reset value would fake a select edge after reset
    snf_sync #(.RST_VAL(1'b1)) u_cs (.clk(clk), .nrst(nrst), .d(chip_select_n), .q(cs_s));
    snf_sync u_sck (.clk(clk), .nrst(nrst), .d(serial_clock), .q(sck_s));
    snf_sync u_si (.clk(clk), .nrst(nrst), .d(serial_in_line), .q(si_s));
    snf_sync u_wp (.clk(clk), .nrst(nrst), .d(write_guard_pin), .q(wp_s));

    logic sck_prev_q, cs_prev_q;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sck_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            cs_prev_q <= cs_s;
        end
    end
    logic sck_rise, sck_fall, cs_fall, cs_rise;
    // edges of the sampled link clock; sampling on rise, driving on fall
    assign sck_rise = sck_s & ~sck_prev_q & ~cs_s;
    assign sck_fall = ~sck_s & sck_prev_q & ~cs_s;
    assign cs_fall = ~cs_s & cs_prev_q;
    assign cs_rise = cs_s & ~cs_prev_q;

    // ------------------------------------------------------------
    // serial shifter and transaction phase
    // ------------------------------------------------------------
    snf_phase_t phase_q;
    logic [7:0] sh_q, opc_q, faddr_q;
    logic [4:0] bitcnt_q;
    logic [ADDR_BITS-1:0] addr_q;
    logic [7:0] out_q;
    logic [2:0] obit_q;
    logic [7:0] byte_in;
    logic byte_done;
    assign byte_in = {sh_q[6:0], si_s};
    assign byte_done = sck_rise && bitcnt_q[2:0] == 3'h7;

    // status and feature state
    logic busy_q, wel_q, efail_q, pfail_q;
    logic [2:0] bp_q;
    logic flip_q, comp_q, wrblk_q, perm_q;
    logic otp_prot_q, otp_en_q;
    logic [7:0] status;
    logic pin_lock, fields_frozen;
    assign status = {4'h0, pfail_q, efail_q, wel_q, busy_q};
    assign pin_lock = wrblk_q & ~wp_s & ~perm_q;
    assign fields_frozen = pin_lock | perm_q;

    // msb-first shift of opcode, address and data bytes
    always_ff @(posedge clk) begin
        if (!nrst) begin
            phase_q <= SNF_IDLE;
            sh_q <= 8'h00;
            bitcnt_q <= 5'h00;
            opc_q <= 8'h00;
            faddr_q <= 8'h00;
            addr_q <= '0;
        end else if (cs_rise) begin
            phase_q <= SNF_IDLE;
        end else if (cs_fall) begin
            phase_q <= SNF_OPC;
            bitcnt_q <= 5'h00;
        end else if (sck_rise) begin
            sh_q <= byte_in;
            bitcnt_q <= bitcnt_q + 5'h01;
            unique case (phase_q)
                SNF_OPC: if (byte_done) begin
                    opc_q <= byte_in;
                    bitcnt_q <= 5'h00;
                    unique case (byte_in)
                        OP_ERASE, OP_PGEXEC, OP_PGREAD: phase_q <= SNF_ADDR;
                        OP_GETF, OP_SETF: phase_q <= SNF_DATA;
                        default: phase_q <= SNF_DROP;
                    endcase
                end
                SNF_ADDR: begin
                    addr_q <= {addr_q[ADDR_BITS-2:0], si_s};
                    if (bitcnt_q == 5'(ADDR_BITS - 1)) phase_q <= SNF_DROP;
                end
                SNF_DATA: if (byte_done) begin
                    faddr_q <= byte_in;
                    phase_q <= (opc_q == OP_GETF) ? SNF_OUT : SNF_DATA;
                    if (opc_q == OP_SETF && bitcnt_q[4:3] != 2'h0) phase_q <= SNF_DROP;
                end
                default: ;
            endcase
        end
    end

    // a write finishes exactly on a byte boundary: full 24 address bits seen
    logic addr_done;
    assign addr_done = (opc_q == OP_ERASE || opc_q == OP_PGEXEC || opc_q == OP_PGREAD) &&
        bitcnt_q == 5'(ADDR_BITS) && phase_q == SNF_DROP;
    logic setf_done;
    assign setf_done = byte_done && phase_q == SNF_DATA && opc_q == OP_SETF && bitcnt_q[4:3] == 2'h1;

    // ------------------------------------------------------------
    // protection decode
    // ------------------------------------------------------------
    logic [BLK_W-1:0] blk;
    logic [BLK_W:0] nlock;
    logic upper, blk_locked;
    assign blk = addr_q[ADDR_BITS-1-(ADDR_BITS-ROW_W) -: BLK_W];
    // fraction of blocks locked is 2^(bp+4) / 2^11; block zero lowest
    always_comb begin
        nlock = (BLK_W+1)'(1) << (BLK_W - 7 + 32'(bp_q));
        upper = ~flip_q;
        blk_locked = 1'b0;
        if (bp_q == 3'h0) blk_locked = 1'b0;
        else if (bp_q == 3'h7) blk_locked = 1'b1;
        else if (bp_q == 3'h6 && comp_q) blk_locked = (blk == '0);
        else begin
            if (comp_q) begin
                nlock = (BLK_W+1)'(1 << BLK_W) - nlock;
                upper = flip_q;
            end
            if (upper) blk_locked = {1'b0, blk} >= (BLK_W+1)'(1 << BLK_W) - nlock;
            else blk_locked = {1'b0, blk} < nlock;
        end
    end

    // ------------------------------------------------------------
    // self-timed operations
    // ------------------------------------------------------------
    logic [CNT_W-1:0] tmr_q;
    logic op_erase_q, op_prog_q;
    logic go_erase, go_prog, go_read, go_otp_lock, erase_ok;
    logic is_otp_page;
    assign is_otp_page = addr_q[PAGE_W-1:0] >= PAGE_W'(OTP_FIRST) &&
        addr_q[PAGE_W-1:0] <= PAGE_W'(OTP_LAST) && blk == '0;
    assign go_erase = cs_rise && addr_done && opc_q == OP_ERASE && wel_q && !busy_q;
    // a refused erase only raises the fail flag and spends no busy time
    assign erase_ok = go_erase && !blk_locked && !otp_en_q;
    assign go_prog = cs_rise && addr_done && opc_q == OP_PGEXEC && wel_q && !busy_q;
    assign go_read = cs_rise && addr_done && opc_q == OP_PGREAD && !busy_q;
    assign go_otp_lock = go_prog && otp_en_q && otp_prot_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tmr_q <= '0;
            busy_q <= 1'b0;
            op_erase_q <= 1'b0;
            op_prog_q <= 1'b0;
        end else if (erase_ok) begin
            tmr_q <= CNT_W'(ERASE_CYCLES);
            busy_q <= 1'b1;
            op_erase_q <= 1'b1;
        end else if (go_prog) begin
            tmr_q <= CNT_W'(PROG_CYCLES);
            busy_q <= 1'b1;
            op_prog_q <= 1'b1;
        end else if (go_read) begin
            tmr_q <= CNT_W'(READ_CYCLES);
            busy_q <= 1'b1;
        end else if (busy_q) begin
            if (tmr_q <= CNT_W'(1)) begin
                busy_q <= 1'b0;
                op_erase_q <= 1'b0;
                op_prog_q <= 1'b0;
            end
            tmr_q <= tmr_q - CNT_W'(1);
        end
    end
    logic done;
    assign done = busy_q && tmr_q <= CNT_W'(1) && (op_erase_q || op_prog_q);

    // erase request toward the array; protected blocks never reach it
    always_ff @(posedge clk) begin
        if (!nrst) begin
            erase_start <= 1'b0;
            erase_block <= '0;
        end else begin
            erase_start <= erase_ok;
            erase_block <= blk;
        end
    end
    assign erase_fail_in_unused = 1'b0;

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wel_q <= 1'b0;
            efail_q <= 1'b0;
            pfail_q <= 1'b0;
        end else begin
            if (byte_done && phase_q == SNF_OPC && byte_in == OP_LATCH_ARM_COMMAND) wel_q <= 1'b1;
            else if (done || (byte_done && phase_q == SNF_OPC && byte_in == OP_WRDI)) wel_q <= 1'b0;
            if (byte_done && phase_q == SNF_OPC && byte_in == OP_RESET) begin
                efail_q <= 1'b0;
                pfail_q <= 1'b0;
            end
            if (go_erase) efail_q <= blk_locked || otp_en_q;
            else if (done && op_erase_q && array_fail) efail_q <= 1'b1;
            if (go_prog) pfail_q <= otp_en_q ? (otp_prot_q ? 1'b0 : !is_otp_page) : blk_locked;
            else if (done && op_prog_q && array_fail) pfail_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // feature registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bp_q <= BP_RESET;
            flip_q <= 1'b0;
            comp_q <= 1'b0;
            wrblk_q <= 1'b0;
            perm_q <= 1'b0;
            otp_en_q <= 1'b0;
        end else if (setf_done) begin
            if (faddr_q == FA_LOCK && !perm_q) begin
                if (!fields_frozen) begin
                    bp_q <= byte_in[LK_BP_HI:LK_BP_LO];
                    flip_q <= byte_in[LK_FLIP];
                    comp_q <= byte_in[LK_COMP];
                end
                if (!pin_lock) wrblk_q <= byte_in[LK_WRBLK];
                perm_q <= byte_in[LK_PERM];
            end
            if (faddr_q == FA_OTP) otp_en_q <= byte_in[OTP_EN];
        end
    end

    // protect bit locked by an execute models non-volatile storage: reset clears only the pending copy
    logic otp_prot_pend_q;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            otp_prot_pend_q <= 1'b0;
        end else if (setf_done && faddr_q == FA_OTP) begin
            otp_prot_pend_q <= byte_in[OTP_PROT];
        end
    end
    logic otp_nv_q = 1'b0;
    always_ff @(posedge clk) begin
        if (go_otp_lock && otp_prot_pend_q) otp_nv_q <= 1'b1;
    end
    assign otp_prot_q = otp_prot_pend_q | otp_nv_q;

    // ------------------------------------------------------------
    // output driver: selected feature byte repeats on falling edges
    // ------------------------------------------------------------
    logic [7:0] feat_sel;
    logic quad_req;
    assign quad_req = byte_done && phase_q == SNF_OPC && (byte_in == OP_QLOAD || byte_in == OP_QRAND);
    always_comb begin
        unique case (faddr_q)
            FA_LOCK: feat_sel = {perm_q, 1'b0, bp_q, flip_q, comp_q, wrblk_q};
            FA_OTP: feat_sel = {otp_prot_q, otp_en_q, 6'h00};
            default: feat_sel = status;
        endcase
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            out_q <= 8'h00;
            obit_q <= 3'h0;
            serial_out_line <= 1'b0;
            serial_out_oe <= 1'b0;
        end else if (cs_rise || phase_q != SNF_OUT) begin
            serial_out_oe <= 1'b0;
            obit_q <= 3'h0;
        end else if (sck_fall) begin
            if (obit_q == 3'h0) begin
                serial_out_line <= feat_sel[7];
                out_q <= {feat_sel[6:0], 1'b0};
            end else begin
                serial_out_line <= out_q[7];
                out_q <= {out_q[6:0], 1'b0};
            end
            obit_q <= obit_q + 3'h1;
            serial_out_oe <= 1'b1;
        end
    end

    // quad loads are dropped while the pin lock holds
    logic quad_ok_unused;
    assign quad_ok_unused = quad_req && !pin_lock;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // accepted erase, then busy held over the following cycles
    sequence s_erase_go;
        erase_ok;
    endsequence
    sequence s_busy_held;
        ##1 busy_q ##1 busy_q;
    endsequence
    chk_erase_busy: assert property (@(posedge clk) disable iff (!nrst)
        s_erase_go |-> s_busy_held) else $error("busy not set after erase");
    chk_erase_start: assert property (@(posedge clk) disable iff (!nrst)
        erase_ok |=> erase_start) else $error("erase not started");
    chk_no_wel_erase: assert property (@(posedge clk) disable iff (!nrst)
        erase_start |-> $past(wel_q)) else $error("erase without latch");
    chk_done_clears: assert property (@(posedge clk) disable iff (!nrst)
        done |=> !busy_q && !wel_q) else $error("done left flags");
    chk_all_locked: assert property (@(posedge clk) disable iff (!nrst)
        bp_q == 3'h7 |-> blk_locked) else $error("code 7 not locking");
    chk_none_locked: assert property (@(posedge clk) disable iff (!nrst)
        bp_q == 3'h0 |-> !blk_locked) else $error("code 0 locking");
    chk_frozen_bp: assert property (@(posedge clk) disable iff (!nrst)
        fields_frozen |=> $stable(bp_q)) else $error("frozen lock changed");
    chk_perm_sticky: assert property (@(posedge clk) disable iff (!nrst)
        perm_q |=> perm_q) else $error("permanent lock dropped");
    chk_reserved: assert property (@(posedge clk) disable iff (!nrst)
        status[7:4] == 4'h0) else $error("reserved bits set");
    chk_locked_fail: assert property (@(posedge clk) disable iff (!nrst)
        go_erase && blk_locked |=> efail_q && !erase_start && !busy_q) else $error("locked erase passed");
endmodule : snf_core
`default_nettype wire

// >>> tb/snf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// serial link host
// ----------------
module snf_host_model (
    input wire logic clk,
    output logic chip_select_n,
    output logic serial_clock,
    output logic serial_in_line,
    input wire logic serial_out_line,
    input wire logic serial_out_oe
);
    // link clock stands still low between frames
    initial begin
        chip_select_n = 1'b1;
        serial_clock = 1'b0;
        serial_in_line = 1'b0;
    end

    // ntx bits out msb first, then nrx bits in; select rises only after a whole bit
    task automatic frame(input logic [31:0] tx, input int ntx, input int nrx, output logic [15:0] rx);
        rx = '0;
        @(posedge clk);
        #1;
        chip_select_n = 1'b0;
        for (int i = 0; i < ntx; i++) begin
            serial_in_line = tx[31-i];
            #62.5 serial_clock = 1'b1;
            #62.5 serial_clock = 1'b0;
        end
        // released line flips so a stale bit never passes for input
        serial_in_line = ~serial_in_line;
        for (int i = 0; i < nrx; i++) begin
            #62.5 serial_clock = 1'b1;
            rx = {rx[14:0], serial_out_oe ? serial_out_line : 1'bx};
            #62.5 serial_clock = 1'b0;
        end
        #62.5 chip_select_n = 1'b1;
        #200;
    endtask : frame
endmodule : snf_host_model
`default_nettype wire

// >>> tb/test_serial_nand_erase_protect_status.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); end end
// -----------------------------
// erase, lock and status bench
// -----------------------------
module test_serial_nand_erase_protect_status;
    import snf_pkg::*;
    // erase shortened so a dozen erases fit the run
    localparam int ERS = 1500;
    localparam int NBLK = 1 << BLK_W;
    logic clk, nrst, cs_n, sclk, si, wg, so, so_oe, e_start, e_unused, afail;
    logic [BLK_W-1:0] e_blk, last_blk;
    int mismatches, n_compared, starts, cyc, t_start, ready_at, b;
    logic [7:0] st, rd, lk;
    logic [15:0] rx;
    logic [7:0] c_lk [8] = '{8'h38, 8'h08, 8'h08, 8'h0C, 8'h32, 8'h32, 8'h3E, 8'h2A};
    int c_blk [8] = '{7, 2047, 2015, 0, 0, 1, 0, 1024};

    snf_core #(.ERASE_CYCLES(ERS), .PROG_CYCLES(500), .READ_CYCLES(200)) i_snf_core (
        .clk(clk), .nrst(nrst), .chip_select_n(cs_n), .serial_clock(sclk), .serial_in_line(si),
        .write_guard_pin(wg), .serial_out_line(so), .serial_out_oe(so_oe), .erase_start(e_start),
        .erase_block(e_blk), .erase_fail_in_unused(e_unused), .array_fail(afail)
    );
    snf_host_model i_snf_host_model (
        .clk(clk), .chip_select_n(cs_n), .serial_clock(sclk), .serial_in_line(si),
        .serial_out_line(so), .serial_out_oe(so_oe)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // erase launches counted with their block and cycle
    always @(posedge clk) begin
        cyc++;
        if (e_start === 1'b1) begin
            starts++;
            last_blk = e_blk;
            t_start = cyc;
        end
    end

    // -----------------
    // expectation logic
    // -----------------
    function automatic logic locked(input logic [7:0] code, input int blk);
        int n;
        n = NBLK >> (7 - code[5:3]);
        if (code[5:3] == 3'h0) return 1'b0;
        if (code[5:3] == 3'h7) return 1'b1;
        if (code[1] && code[5:3] == 3'h6) return blk == 0;
        if (!code[1]) return code[2] ? blk < n : blk >= NBLK - n;
        return code[2] ? blk >= n : blk < NBLK - n;
    endfunction : locked

    // ----------
    // link tasks
    // ----------
    task automatic cmd(input logic [7:0] op);
        i_snf_host_model.frame({op, 24'h0}, 8, 0, rx);
    endtask : cmd

    task automatic setf(input logic [7:0] fa, input logic [7:0] d);
        i_snf_host_model.frame({OP_SETF, fa, d, 8'h0}, 24, 0, rx);
    endtask : setf

    task automatic getf(input logic [7:0] fa, output logic [7:0] d);
        i_snf_host_model.frame({OP_GETF, fa, 16'h0}, 16, 8, rx);
        d = rx[7:0];
    endtask : getf

    // any page of the block, random dummy bits above the row
    task automatic erase(input int blk, input int nbits);
        logic [23:0] addr;
        addr = {7'($urandom), blk[BLK_W-1:0], 6'($urandom)};
        i_snf_host_model.frame({OP_ERASE, addr}, 8 + nbits, 0, rx);
    endtask : erase

    task automatic wait_ready(output logic [7:0] s);
        for (int k = 0; k < 60; k++) begin
            getf(FA_STATUS, s);
            if (s[0] === 1'b0) break;
        end
        ready_at = cyc;
        `CHK(s[0], 1'b0);
    endtask : wait_ready

    task automatic erase_check(input int blk, input logic [7:0] code);
        int s0;
        s0 = starts;
        cmd(OP_LATCH_ARM_COMMAND);
        erase(blk, 24);
        getf(FA_STATUS, st);
        if (!locked(code, blk)) begin
            `CHK(st, 8'h03);
            `CHK(starts, s0 + 1);
            `CHK(last_blk, blk[BLK_W-1:0]);
            wait_ready(st);
            `CHK(st, {5'h0, afail, 2'h0});
            `CHK(1'(ready_at - t_start >= ERS && ready_at - t_start <= ERS + 500), 1'b1);
        end else begin
            `CHK(starts, s0);
            `CHK(st[2], 1'b1);
            cmd(OP_WRDI);
        end
    endtask : erase_check

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask : done

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    // ---------
    // sequence
    // ---------
    initial begin
        void'($urandom(27));
        nrst = 1'b0;
        wg = 1'b1;
        afail = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge clk);
        getf(FA_LOCK, rd);
        `CHK(rd, 8'h38);
        getf(FA_STATUS, rd);
        `CHK(rd, 8'h00);
        getf(FA_OTP, rd);
        `CHK(rd, 8'h00);
        `CHK(e_unused, 1'b0);
        done("reset");
        // status keeps repeating within one frame
        cmd(OP_LATCH_ARM_COMMAND);
        i_snf_host_model.frame({OP_GETF, FA_STATUS, 16'h0}, 16, 16, rx);
        `CHK(rx, 16'h0202);
        cmd(OP_WRDI);
        getf(FA_STATUS, rd);
        `CHK(rd, 8'h00);
        done("latch");
        // unarmed erase and a 23-bit address are both dropped
        setf(FA_LOCK, 8'h00);
        getf(FA_LOCK, rd);
        `CHK(rd, 8'h00);
        erase(9, 24);
        cmd(OP_LATCH_ARM_COMMAND);
        erase(9, 23);
        getf(FA_STATUS, rd);
        `CHK(rd, 8'h02);
        `CHK(starts, 0);
        cmd(OP_WRDI);
        done("refused");
        for (int i = 0; i < 12; i++) begin
            lk = i < 8 ? c_lk[i] : 8'($urandom) & 8'h3E;
            b = i < 8 ? c_blk[i] : int'($urandom % NBLK);
            @(posedge clk);
            #1;
            afail = 1'($urandom % 3 == 0);
            setf(FA_LOCK, lk);
            erase_check(b, lk);
        end
        done("decode");
        setf(FA_LOCK, 8'h01);
        @(posedge clk);
        #1;
        wg = 1'b0;
        setf(FA_LOCK, 8'h38);
        getf(FA_LOCK, rd);
        `CHK(rd, 8'h01);
        @(posedge clk);
        #1;
        wg = 1'b1;
        setf(FA_LOCK, 8'h00);
        getf(FA_LOCK, rd);
        `CHK(rd, 8'h00);
        setf(FA_OTP, 8'h40);
        getf(FA_OTP, rd);
        `CHK(rd, 8'h40);
        setf(FA_OTP, 8'h00);
        getf(FA_OTP, rd);
        `CHK(rd, 8'h00);
        done("pin_otp");
        setf(FA_LOCK, 8'h80);
        setf(FA_LOCK, 8'h38);
        getf(FA_LOCK, rd);
        `CHK(rd, 8'h80);
        @(posedge clk);
        #1;
        afail = 1'b1;
        erase_check(5, 8'h80);
        @(posedge clk);
        #1;
        afail = 1'b0;
        cmd(OP_RESET);
        wait_ready(st);
        `CHK(st, 8'h00);
        done("permanent");
        finish_test();
    end

    // a hang ends the run; about three times the expected length, under the cycle budget
    initial begin
        #900000;
        mismatches++;
        finish_test();
    end
endmodule : test_serial_nand_erase_protect_status
`default_nettype wire
